/* File: rtl/lsp_ctrl.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Notes on behaviour
// ------------------------------------------------------------------
// Notes on behaviour
// - Current-limit field 0x21[7:5], default 001.
// - Overvoltage opens load switch within 1 us.
// - Overvoltage sets overvoltage event flag.
// - Reclose after 9 ms deglitch of recovery.
// - Overvoltage clearing sets protection-cleared flag.
// - Over-temperature opens switch until cooled down.
// - Standby after power-up or no accessory in the on state.
// - Standby keeps sampling VBUS and ID comparators.
// - USB or UART switch on in 130 us.
// - Microphone routes to VBUS or D+, never both.
// - Overcurrent field 0x22[2:0], default 001.
// - Overcurrent persisting past timeout disables switch.
module lsp_ctrl
  import lsp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Analog comparator outputs, asynchronous
  input wire lsp_sense_t sense_in,
  input wire logic vbus_present_in,
  // Register port from the serial interface, same clock
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic ack_in,
  output logic [7:0] reg_rdata_out,
  // Load switch, analog limit codes and standby indication
  output logic load_switch_on_out,
  output logic [2:0] current_limit_level_out,
  output logic [2:0] overcurrent_trip_level_out,
  output logic standby_out,
  // Switch matrix drives
  output lsp_paths_t paths_out,
  // Host interrupt
  output logic host_interrupt_output_out
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  lsp_sense_t sense_m_q; // First stage, read only by second stage
  lsp_sense_t sense_q;   // Usable comparator levels
  logic vbus_m_q;
  logic vbus_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sense_m_q <= '0;
      sense_q <= '0;
      vbus_m_q <= 1'b0;
      vbus_q <= 1'b0;
    end else begin
      sense_m_q <= sense_in;
      sense_q <= sense_m_q;
      vbus_m_q <= vbus_present_in;
      vbus_q <= vbus_m_q;
    end
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] cur_limit_q, cur_limit_d;  // Current-limit config
  logic [7:0] ocp_q, ocp_d;              // Overcurrent config
  logic [7:0] sw_req_q, sw_req_d;        // Requested switch state
  logic ov_flag_q, ov_flag_d;            // Overvoltage event flag
  logic clr_flag_q, clr_flag_d;          // Protection cleared flag
  logic [7:0] rdata_q, rdata_d;
  logic load_sw_q, load_sw_d;            // Load switch drive, also in status
  logic standby_q, standby_d;            // Standby indication, also in status
  logic ov_event, clr_event;
  logic rd_flags;
  always_comb begin
    cur_limit_d = cur_limit_q;
    ocp_d = ocp_q;
    sw_req_d = sw_req_q;
    rd_flags = reg_rd_in && (reg_addr_in == LSP_OFS_FLAGS);
    // Reading the flags clears them; a new event wins
    ov_flag_d = (ov_flag_q && !rd_flags) || ov_event;
    clr_flag_d = (clr_flag_q && !rd_flags) || clr_event;
    if (reg_wr_in) begin
      case (reg_addr_in)
        LSP_OFS_CUR_LIMIT: cur_limit_d = reg_wdata_in;
        LSP_OFS_OCP: ocp_d = reg_wdata_in;
        LSP_OFS_SWITCH: sw_req_d = reg_wdata_in;
        default: ;
      endcase
    end
    rdata_d = rdata_q;
    if (reg_rd_in) begin
      case (reg_addr_in)
        LSP_OFS_CUR_LIMIT: rdata_d = cur_limit_q;
        LSP_OFS_OCP: rdata_d = ocp_q;
        LSP_OFS_SWITCH: rdata_d = sw_req_q;
        LSP_OFS_FLAGS: rdata_d = {6'h00, clr_flag_q, ov_flag_q};
        LSP_OFS_STATUS: rdata_d = {3'h0, sense_q.otp_hot, sense_q.oc, sense_q.ovp, load_sw_q, standby_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_limit_q <= LSP_CUR_LIMIT_RST;
      ocp_q <= LSP_OCP_RST;
      sw_req_q <= LSP_SWITCH_RST;
      ov_flag_q <= 1'b0;
      clr_flag_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cur_limit_q <= cur_limit_d;
      ocp_q <= ocp_d;
      sw_req_q <= sw_req_d;
      ov_flag_q <= ov_flag_d;
      clr_flag_q <= clr_flag_d;
      rdata_q <= rdata_d;
    end
  end
  // ----------------------------------------------------------------
  // Load switch protection state machine
  // ----------------------------------------------------------------
  lsp_state_t state_q, state_d;
  logic [LSP_CNT_W-1:0] cnt_q, cnt_d;      // Recovery deglitch counter
  logic [LSP_CNT_W-1:0] oc_cnt_q, oc_cnt_d; // Overcurrent timeout counter
  logic hot_q, hot_d;                       // Over-temperature latch
  logic oc_trip_q, oc_trip_d;               // Overcurrent shutdown latch
  logic ov_seen_q, ov_seen_d;               // Overvoltage remembered
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ov_event = 1'b0;
    clr_event = 1'b0;
    ov_seen_d = ov_seen_q;
    // Hot trips, released only at cool level
    hot_d = hot_q;
    if (sense_q.otp_hot) begin
      hot_d = 1'b1;
    end else if (sense_q.otp_cool) begin
      hot_d = 1'b0;
    end
    // Overcurrent timeout
    oc_cnt_d = '0;
    oc_trip_d = oc_trip_q;
    if (sense_q.oc && !oc_trip_q) begin
      oc_cnt_d = oc_cnt_q + 1'b1;
      if (oc_cnt_q >= LSP_CNT_W'(LSP_OCP_TMO_CYC - 1)) begin
        oc_trip_d = 1'b1;
      end
    end
    if (!vbus_q) begin
      oc_trip_d = 1'b0;
    end
    case (state_q)
      LSP_ST_STANDBY: begin
        if (vbus_q || sense_q.id_att) begin
          state_d = LSP_ST_ON;
        end
      end
      LSP_ST_ON: begin
        if (sense_q.ovp) begin
          state_d = LSP_ST_FAULT;
          ov_event = 1'b1;
          ov_seen_d = 1'b1;
        end else if (!vbus_q && !sense_q.id_att) begin
          state_d = LSP_ST_STANDBY;
        end
      end
      LSP_ST_FAULT: begin
        cnt_d = '0;
        if (!sense_q.ovp && sense_q.ov_clear && sense_q.uvlo_ok) begin
          state_d = LSP_ST_RECOVER;
        end
      end
      LSP_ST_RECOVER: begin
        if (sense_q.ovp || !sense_q.ov_clear || !sense_q.uvlo_ok) begin
          state_d = LSP_ST_FAULT;
        end else if (cnt_q >= LSP_CNT_W'(LSP_DEGLITCH_CYC - 1)) begin
          state_d = LSP_ST_ON;
          clr_event = ov_seen_q;
          ov_seen_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: state_d = LSP_ST_STANDBY;
    endcase
    // Overvoltage opens the switch the cycle it is seen
    load_sw_d = (state_d == LSP_ST_ON) && vbus_q && !sense_q.ovp && !hot_d && !oc_trip_d;
    standby_d = (state_d == LSP_ST_STANDBY);
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= LSP_ST_STANDBY;
      cnt_q <= '0;
      oc_cnt_q <= '0;
      hot_q <= 1'b0;
      oc_trip_q <= 1'b0;
      load_sw_q <= 1'b0;
      standby_q <= 1'b1;
      ov_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      oc_cnt_q <= oc_cnt_d;
      hot_q <= hot_d;
      oc_trip_q <= oc_trip_d;
      load_sw_q <= load_sw_d;
      standby_q <= standby_d;
      ov_seen_q <= ov_seen_d;
    end
  end
  // ----------------------------------------------------------------
  // Switch sequencing after acknowledged write
  // ----------------------------------------------------------------
  logic [4:0] want;
  logic [4:0] cur_q, cur_d;
  logic [4:0] pend_q, pend_d;
  logic [LSP_CNT_W-1:0] swc_q [5];
  logic [LSP_CNT_W-1:0] swc_d [5];
  logic [LSP_CNT_W-1:0] lim [5];
  always_comb begin
    want = 5'h00;
    want[0] = sw_req_q[LSP_SW_AUDIO];
    want[1] = sw_req_q[LSP_SW_USB];
    want[2] = sw_req_q[LSP_SW_UART];
    // Only one microphone source, D+ takes precedence
    want[3] = sw_req_q[LSP_SW_MIC_EN] && !sw_req_q[LSP_SW_MIC_DP];
    want[4] = sw_req_q[LSP_SW_MIC_EN] && sw_req_q[LSP_SW_MIC_DP];
  end
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sw
      always_comb begin
        if (g == 0) begin
          lim[g] = want[g] ? LSP_CNT_W'(LSP_AUD_ON_CYC) : LSP_CNT_W'(LSP_AUD_OFF_CYC);
        end else begin
          lim[g] = want[g] ? LSP_CNT_W'(LSP_USB_ON_CYC) : LSP_CNT_W'(LSP_USB_OFF_CYC);
        end
        pend_d[g] = pend_q[g];
        swc_d[g] = swc_q[g];
        cur_d[g] = cur_q[g];
        if (ack_in && (want[g] != cur_q[g])) begin
          pend_d[g] = 1'b1;
          swc_d[g] = '0;
        end else if (pend_q[g]) begin
          swc_d[g] = swc_q[g] + 1'b1;
          if (swc_q[g] >= lim[g] - 1'b1) begin
            pend_d[g] = 1'b0;
            cur_d[g] = want[g];
          end
        end
      end
      always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pend_q[g] <= 1'b0;
          swc_q[g] <= '0;
          cur_q[g] <= 1'b0;
        end else begin
          pend_q[g] <= pend_d[g];
          swc_q[g] <= swc_d[g];
          cur_q[g] <= cur_d[g];
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  logic irq_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= ov_flag_d || clr_flag_d;
    end
  end
  assign reg_rdata_out = rdata_q;
  assign load_switch_on_out = load_sw_q;
  assign current_limit_level_out = cur_limit_q[LSP_CL_MSB:LSP_CL_LSB];
  assign overcurrent_trip_level_out = ocp_q[LSP_OCP_MSB:LSP_OCP_LSB];
  assign standby_out = standby_q;
  assign paths_out = '{audio: cur_q[0], usb: cur_q[1], uart: cur_q[2], mic_vbus: cur_q[3], mic_dp: cur_q[4]};
  assign host_interrupt_output_out = irq_q;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ovp_opens_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    sense_q.ovp |=> !load_sw_q) else $error("load switch closed during overvoltage");
  ov_flag_set_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    ov_event |=> ov_flag_q) else $error("overvoltage flag not set");
  recover_wait_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (state_q == LSP_ST_RECOVER && state_d == LSP_ST_ON) |-> cnt_q == LSP_CNT_W'(LSP_DEGLITCH_CYC - 1))
    else $error("reclosed before deglitch");
  clr_flag_set_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    clr_event |=> clr_flag_q) else $error("cleared flag not set");
  hot_holds_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    hot_q && !sense_q.otp_cool |=> !load_sw_q) else $error("switch closed while hot");
  standby_state_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    standby_q |-> !load_sw_q) else $error("load switch on in standby");
  mic_exclusive_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !(cur_q[3] && cur_q[4])) else $error("mic routed to two sources");
  oc_disable_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    oc_trip_q |-> !load_sw_q) else $error("switch on after overcurrent trip");
  irq_follows_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (ov_flag_q || clr_flag_q) |-> irq_q) else $error("interrupt low with flag set");
  cl_default_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    $rose(resetn_in) |-> cur_limit_q[LSP_CL_MSB:LSP_CL_LSB] == 3'h1) else $error("limit default wrong");
endmodule : lsp_ctrl

/* File: rtl/lsp_pkg.sv */
package lsp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LSP_OFS_CUR_LIMIT = 8'h21; // Current-limit config
  localparam logic [7:0] LSP_OFS_OCP = 8'h22;       // Overcurrent trip config
  localparam logic [7:0] LSP_OFS_FLAGS = 8'h03;     // Event flags, read clears
  localparam logic [7:0] LSP_OFS_SWITCH = 8'h04;    // Manual switch control
  localparam logic [7:0] LSP_OFS_STATUS = 8'h05;    // Live protection status
  localparam int LSP_CL_MSB = 7;                    // Current-limit field top
  localparam int LSP_CL_LSB = 5;                    // Current-limit field bottom
  localparam int LSP_OCP_MSB = 2;                   // Trip field top
  localparam int LSP_OCP_LSB = 0;                   // Trip field bottom
  localparam logic [7:0] LSP_CUR_LIMIT_RST = 8'h20; // Field code 001
  localparam logic [7:0] LSP_OCP_RST = 8'h01;       // Field code 001
  localparam logic [7:0] LSP_SWITCH_RST = 8'h00;    // All paths off
  // Switch control bit positions
  localparam int LSP_SW_AUDIO = 0;
  localparam int LSP_SW_USB = 1;
  localparam int LSP_SW_UART = 2;
  localparam int LSP_SW_MIC_EN = 3;
  localparam int LSP_SW_MIC_DP = 4;
  // ----------------------------------------------------------------
  // Timing at 25 MHz
  // ----------------------------------------------------------------
  localparam int LSP_CLK_HZ = 25000000;
  localparam int LSP_OVP_OFF_NS = 1000;             // Longest shutoff time
  localparam int LSP_OVP_OFF_CYC = LSP_OVP_OFF_NS / 40;
  localparam int LSP_DEGLITCH_MS = 9;               // Recovery deglitch
  localparam int LSP_DEGLITCH_CYC = LSP_CLK_HZ / 1000 * LSP_DEGLITCH_MS;
  localparam int LSP_AUD_ON_US = 200;
  localparam int LSP_AUD_OFF_US = 100;
  localparam int LSP_USB_ON_US = 130;
  localparam int LSP_USB_OFF_US = 100;
  localparam int LSP_AUD_ON_CYC = LSP_CLK_HZ / 1000000 * LSP_AUD_ON_US;
  localparam int LSP_AUD_OFF_CYC = LSP_CLK_HZ / 1000000 * LSP_AUD_OFF_US;
  localparam int LSP_USB_ON_CYC = LSP_CLK_HZ / 1000000 * LSP_USB_ON_US;
  localparam int LSP_USB_OFF_CYC = LSP_CLK_HZ / 1000000 * LSP_USB_OFF_US;
  localparam int LSP_OCP_TMO_US = 100;              // Overcurrent timeout
  localparam int LSP_OCP_TMO_CYC = LSP_CLK_HZ / 1000000 * LSP_OCP_TMO_US;
  localparam int LSP_CNT_W = 24;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LSP_ST_STANDBY = 2'b00,
    LSP_ST_ON = 2'b01,
    LSP_ST_FAULT = 2'b10,
    LSP_ST_RECOVER = 2'b11
  } lsp_state_t;
  typedef struct packed {
    logic ovp;       // Voltage above overvoltage threshold
    logic ov_clear;  // Below threshold minus hysteresis
    logic uvlo_ok;   // Above undervoltage lockout level
    logic oc;        // Current above overcurrent trip level
    logic otp_hot;   // Temperature rose past hot trip
    logic otp_cool;  // Temperature fell to cool release
    logic id_att;    // ID comparator sees an accessory
  } lsp_sense_t;
  typedef struct packed {
    logic audio;
    logic usb;
    logic uart;
    logic mic_vbus;
    logic mic_dp;
  } lsp_paths_t;
endpackage : lsp_pkg

/* File: sim/lsp_host_model.sv */
`timescale 1ns/1ps
// ----
// Host side of the register port
// ----
module lsp_host_model
  import lsp_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Strobes and data
  output logic wr_out,
  output logic rd_out,
  output logic ack_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  // Answer
  input wire logic [7:0] rdata_in
);
  // Idle bus at time zero
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    ack_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // One write strobe; released lines show the inverse
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : wr_reg
  // One read strobe; data is registered one cycle later
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    rd_out = 1'b1;
    addr_out = a;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd_reg
  // Acknowledge pulse that starts switch sequencing
  task automatic ack_pulse();
    @(posedge clk_in);
    #1;
    ack_out = 1'b1;
    @(posedge clk_in);
    #1;
    ack_out = 1'b0;
  endtask : ack_pulse
endmodule : lsp_host_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import lsp_pkg::*;
  logic sys_clk_in, resetn_in, vbus_present_in, reg_wr_in, reg_rd_in, ack_in;
  lsp_sense_t sense_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
  logic load_switch_on_out, standby_out, host_interrupt_output_out;
  logic [2:0] current_limit_level_out, overcurrent_trip_level_out;
  lsp_paths_t paths_out;
  logic [5:0] watch; // Load switch above the five paths
  int num_errors, samples_checked, i, n, m;
  integer seed; // Seed variable for $random
  logic [7:0] mdl_reg [int]; // Expected register contents
  assign watch = {load_switch_on_out, paths_out};
  lsp_ctrl u_lsp_ctrl (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .sense_in(sense_in),
    .vbus_present_in(vbus_present_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .ack_in(ack_in),
    .reg_rdata_out(reg_rdata_out), .load_switch_on_out(load_switch_on_out),
    .current_limit_level_out(current_limit_level_out),
    .overcurrent_trip_level_out(overcurrent_trip_level_out), .standby_out(standby_out),
    .paths_out(paths_out), .host_interrupt_output_out(host_interrupt_output_out));
  lsp_host_model u_lsp_host_model (.clk_in(sys_clk_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .ack_out(ack_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out));
  // Clock, 40 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // ----
  // Checking helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // Read and compare with the model
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] v;
    u_lsp_host_model.rd_reg(a, v);
    check(v, mdl_reg.exists(a) ? mdl_reg[a] : 8'h00, "read");
  endtask : rd_chk
  // Bounded wait for one watched bit
  task automatic wait_bit(input int b, input logic lvl, input int lim, output int k);
    k = 0;
    while (watch[b] !== lvl) begin
      @(posedge sys_clk_in);
      #1;
      k++;
      if (k > lim) begin
        check({7'h00, watch[b]}, {7'h00, lvl}, "wait bound");
        report_and_stop();
      end
    end
  endtask : wait_bit
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  // Switch delay within three cycles
  task automatic near(input int k, input int exp);
    check({7'h00, (k >= exp - 3) && (k <= exp + 3)}, 8'h01, "switch delay");
  endtask : near
  // Microphone never on both sources, sampled away from the launching edge
  always @(negedge sys_clk_in) begin
    if (paths_out.mic_vbus === 1'b1 && paths_out.mic_dp === 1'b1) begin
      check(8'h01, 8'h00, "mic both");
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    seed = 32'hB1A0;
    num_errors = 0;
    samples_checked = 0;
    resetn_in = 1'b0;
    vbus_present_in = 1'b0;
    sense_in = '0;
    mdl_reg[8'h21] = LSP_CUR_LIMIT_RST;
    mdl_reg[8'h22] = LSP_OCP_RST;
    mdl_reg[8'h04] = LSP_SWITCH_RST;
    cyc(8);
    resetn_in = 1'b1;
    check({7'h00, standby_out}, 8'h01, "standby");
    check({7'h00, load_switch_on_out}, 8'h00, "load");
    check({5'h00, current_limit_level_out}, 8'h01, "limit");
    check({5'h00, overcurrent_trip_level_out}, 8'h01, "trip");
    rd_chk(8'h21);
    rd_chk(8'h22);
    rd_chk(8'h7F);
    // Every code of both limit fields
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[7:5] = 3'(i);
      mdl_reg[8'h21] = d;
      mdl_reg[8'h22] = {5'h00, 3'(i)};
      u_lsp_host_model.wr_reg(8'h21, d);
      u_lsp_host_model.wr_reg(8'h22, {5'h00, 3'(i)});
      rd_chk(8'h21);
      rd_chk(8'h22);
      check({5'h00, current_limit_level_out}, {5'h00, d[7:5]}, "limit code");
      check({5'h00, overcurrent_trip_level_out}, {5'h00, 3'(i)}, "trip code");
    end
    $display("test registers done");
    // ID alone leaves standby, then returns
    sense_in.id_att = 1'b1;
    cyc(8);
    check({7'h00, standby_out}, 8'h00, "id exit");
    sense_in.id_att = 1'b0;
    cyc(8);
    check({7'h00, standby_out}, 8'h01, "no accessory");
    vbus_present_in = 1'b1;
    sense_in.uvlo_ok = 1'b1;
    sense_in.ov_clear = 1'b1;
    cyc(8);
    check({7'h00, standby_out}, 8'h00, "vbus exit");
    wait_bit(5, 1'b1, 10000, n);
    $display("test standby done");
    // Over-temperature with hysteresis
    sense_in.otp_hot = 1'b1;
    wait_bit(5, 1'b0, 25, n);
    sense_in.otp_hot = 1'b0;
    cyc(200);
    check({7'h00, load_switch_on_out}, 8'h00, "hot hold");
    sense_in.otp_cool = 1'b1;
    wait_bit(5, 1'b1, 10000, n);
    sense_in.otp_cool = 1'b0;
    $display("test temperature done");
    // Short excursion survives, long one trips
    sense_in.oc = 1'b1;
    cyc(LSP_OCP_TMO_CYC - 500);
    sense_in.oc = 1'b0;
    cyc(600);
    check({7'h00, load_switch_on_out}, 8'h01, "short oc");
    sense_in.oc = 1'b1;
    wait_bit(5, 1'b0, LSP_OCP_TMO_CYC + 20, n);
    check({7'h00, n > LSP_OCP_TMO_CYC - 20}, 8'h01, "oc early");
    sense_in.oc = 1'b0;
    vbus_present_in = 1'b0;
    cyc(20);
    vbus_present_in = 1'b1;
    wait_bit(5, 1'b1, 10000, n);
    $display("test overcurrent done");
    // Overvoltage shutoff, flag, deglitch hold
    sense_in.ov_clear = 1'b0;
    sense_in.ovp = 1'b1;
    wait_bit(5, 1'b0, LSP_OVP_OFF_CYC, n);
    cyc(2);
    check({7'h00, host_interrupt_output_out}, 8'h01, "irq set");
    u_lsp_host_model.rd_reg(LSP_OFS_FLAGS, d);
    check(d, 8'h01, "ov flag");
    sense_in.ovp = 1'b0;
    sense_in.ov_clear = 1'b1;
    cyc(2000);
    check({7'h00, load_switch_on_out}, 8'h00, "deglitch");
    u_lsp_host_model.rd_reg(LSP_OFS_FLAGS, d);
    check(d, 8'h00, "flags cleared");
    cyc(2);
    check({7'h00, host_interrupt_output_out}, 8'h00, "irq clear");
    $display("test overvoltage done");
    // Switch sequencing from the acknowledge
    u_lsp_host_model.wr_reg(LSP_OFS_SWITCH, 8'h02);
    u_lsp_host_model.ack_pulse();
    wait_bit(3, 1'b1, 6000, n);
    near(n, LSP_USB_ON_CYC);
    u_lsp_host_model.wr_reg(LSP_OFS_SWITCH, 8'h01);
    u_lsp_host_model.ack_pulse();
    wait_bit(3, 1'b0, 6000, n);
    wait_bit(4, 1'b1, 6000, m);
    near(n + m, LSP_AUD_ON_CYC);
    u_lsp_host_model.wr_reg(LSP_OFS_SWITCH, 8'h04);
    u_lsp_host_model.ack_pulse();
    wait_bit(4, 1'b0, 6000, n);
    near(n, LSP_AUD_OFF_CYC);
    wait_bit(2, 1'b1, 6000, m);
    near(n + m, LSP_USB_ON_CYC);
    u_lsp_host_model.wr_reg(LSP_OFS_SWITCH, 8'h08);
    u_lsp_host_model.ack_pulse();
    wait_bit(1, 1'b1, 8000, n);
    check({7'h00, paths_out.mic_dp}, 8'h00, "mic vbus");
    u_lsp_host_model.wr_reg(LSP_OFS_SWITCH, 8'h18);
    u_lsp_host_model.ack_pulse();
    wait_bit(0, 1'b1, 8000, n);
    check({7'h00, paths_out.mic_vbus}, 8'h00, "mic dp");
    $display("test switches done");
    report_and_stop();
  end
endmodule : tb
